//--- dsp_serial_top.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"
module dsp_serial_top
  import dsp_pkg::*;
#(
  parameter int FIFO_DEPTH = `DSP_FIFO_DEPTH_DEF
) (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic [11:0] reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [31:0] reg_wdata,
  output logic      [31:0] reg_rdata,
  output logic             reg_rvalid,
  output logic             tx_valid,
  output logic      [7:0]  tx_byte,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [31:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ack,
  output logic             irq
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  dsp_fifo_if #(.DEPTH(FIFO_DEPTH)) rxf ();

  dsp_rx_fifo #(.DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clock (clock),
    .rst_b (rst_b),
    .f     (rxf.fifo)
  );

  logic [`DSP_MASK_W-1:0] mask_q;
  logic [31:0]            tx_ptr_q;
  logic [31:0]            tx_rem_q;
  logic [31:0]            rx_ptr_q;
  logic [31:0]            rx_rem_q;
  logic                   tx_pend_q;
  dsp_byte_t              tx_pend_byte_q;
  dsp_mem_e               mem_state_q;
  logic [31:0]            rdata_q;
  logic                   rvalid_q;
  logic                   txv_q;
  dsp_byte_t              txb_q;
  logic                   req_q;
  logic                   we_q;
  logic [31:0]            maddr_q;
  dsp_byte_t              mwdata_q;
  logic                   irq_q;

  // Register decode
  wire wr_byte   = reg_wr && (reg_addr == `DSP_OFF_BYTE_PORT);
  wire wr_mask   = reg_wr && (reg_addr == `DSP_OFF_MASK);
  wire wr_tx_ptr = reg_wr && (reg_addr == `DSP_OFF_TX_PTR);
  wire wr_tx_rem = reg_wr && (reg_addr == `DSP_OFF_TX_REM);
  wire wr_rx_ptr = reg_wr && (reg_addr == `DSP_OFF_RX_PTR);
  wire wr_rx_rem = reg_wr && (reg_addr == `DSP_OFF_RX_REM);
  wire rd_byte   = reg_rd && (reg_addr == `DSP_OFF_BYTE_PORT);
  wire sw_pop    = rd_byte && !rxf.empty;

  // Interrupt sources are live levels, no sticky state
  wire src_rxne  = !rxf.empty;
  wire src_txz   = (tx_rem_q == `DSP_ZERO_WORD);
  wire src_rxz   = (rx_rem_q == `DSP_ZERO_WORD);
  wire [`DSP_MASK_W-1:0] src_vec = {src_rxz, src_txz, src_rxne};
  wire irq_d     = |(src_vec & mask_q);

  // Channel launch: software pops take the queue first, receive wins the port
  wire mem_idle  = (mem_state_q == DSP_MEM_IDLE);
  // A count write in the decide cycle wins, so a zero write never launches
  wire rx_go     = mem_idle && !src_rxz && !rxf.empty && !sw_pop && !wr_rx_rem;
  wire tx_go     = mem_idle && !src_txz && !tx_pend_q && !rx_go && !wr_tx_rem;
  wire tx_ack    = (mem_state_q == DSP_MEM_TX) && mem_ack;
  wire rx_ack    = (mem_state_q == DSP_MEM_RX) && mem_ack;
  // Abort: an answer for a channel whose count went to zero is thrown away
  wire tx_step   = tx_ack && !src_txz && !wr_tx_rem;
  wire rx_step   = rx_ack && !src_rxz && !wr_rx_rem;
  // Byte port writes win over the pending channel byte on the serial side
  wire pend_send = tx_pend_q && !wr_byte;

  assign rxf.push      = rx_valid;
  assign rxf.push_data = rx_byte;
  assign rxf.pop       = sw_pop || rx_go;

  // Read data selection
  logic [31:0] rd_mux;
  always_comb begin
    case (reg_addr)
      `DSP_OFF_IDENT:     rd_mux = `DSP_IDENT_VALUE;
      `DSP_OFF_BYTE_PORT: rd_mux = rxf.empty ? `DSP_EMPTY_READ : {24'h00_0000, rxf.head};
      `DSP_OFF_FILL:      rd_mux = 32'(rxf.count);
      `DSP_OFF_MASK:      rd_mux = 32'(mask_q);
      `DSP_OFF_TX_PTR:    rd_mux = tx_ptr_q;
      `DSP_OFF_TX_REM:    rd_mux = tx_rem_q;
      `DSP_OFF_RX_PTR:    rd_mux = rx_ptr_q;
      `DSP_OFF_RX_REM:    rd_mux = rx_rem_q;
      `DSP_OFF_DEPTH:     rd_mux = 32'(FIFO_DEPTH);
      default:            rd_mux = `DSP_ZERO_WORD;
    endcase
  end

  // Register read answer, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rdata_q  <= `DSP_ZERO_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // Mask and interrupt output
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mask_q <= `DSP_MASK_RESET;
      irq_q  <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask_q <= reg_wdata[`DSP_MASK_W-1:0];
      end
      irq_q <= irq_d;
    end
  end

  // Transmit channel: address and count owned by this channel alone
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      tx_ptr_q <= `DSP_ZERO_WORD;
      tx_rem_q <= `DSP_ZERO_WORD;
    end else begin
      if (wr_tx_ptr) begin
        tx_ptr_q <= reg_wdata;
      end else if (tx_step) begin
        tx_ptr_q <= tx_ptr_q + `DSP_ONE_WORD;
      end
      if (wr_tx_rem) begin
        tx_rem_q <= reg_wdata;
      end else if (tx_step) begin
        tx_rem_q <= tx_rem_q - `DSP_ONE_WORD;
      end
    end
  end

  // Receive channel, independent of the transmit one
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      rx_ptr_q <= `DSP_ZERO_WORD;
      rx_rem_q <= `DSP_ZERO_WORD;
    end else begin
      if (wr_rx_ptr) begin
        rx_ptr_q <= reg_wdata;
      end else if (rx_step) begin
        rx_ptr_q <= rx_ptr_q + `DSP_ONE_WORD;
      end
      if (wr_rx_rem) begin
        rx_rem_q <= reg_wdata;
      end else if (rx_step) begin
        rx_rem_q <= rx_rem_q - `DSP_ONE_WORD;
      end
    end
  end

  // Memory master: one outstanding access, held until acknowledged
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mem_state_q <= DSP_MEM_IDLE;
      req_q       <= 1'b0;
      we_q        <= 1'b0;
      maddr_q     <= `DSP_ZERO_WORD;
      mwdata_q    <= 8'h00;
    end else begin
      case (mem_state_q)
        DSP_MEM_IDLE: begin
          if (rx_go) begin
            mem_state_q <= DSP_MEM_RX;
            req_q       <= 1'b1;
            we_q        <= 1'b1;
            maddr_q     <= rx_ptr_q;
            mwdata_q    <= rxf.head;
          end else if (tx_go) begin
            mem_state_q <= DSP_MEM_TX;
            req_q       <= 1'b1;
            we_q        <= 1'b0;
            maddr_q     <= tx_ptr_q;
          end
        end
        DSP_MEM_TX, DSP_MEM_RX: begin
          if (mem_ack) begin
            mem_state_q <= DSP_MEM_IDLE;
            req_q       <= 1'b0;
          end
        end
        default: begin
          mem_state_q <= DSP_MEM_IDLE;
          req_q       <= 1'b0;
        end
      endcase
    end
  end

  // Serial output; a fetched byte waits one slot if software sends first
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      txv_q          <= 1'b0;
      txb_q          <= 8'h00;
      tx_pend_q      <= 1'b0;
      tx_pend_byte_q <= 8'h00;
    end else begin
      txv_q <= wr_byte || tx_pend_q;
      if (wr_byte) begin
        txb_q <= reg_wdata[7:0];
      end else if (tx_pend_q) begin
        txb_q <= tx_pend_byte_q;
      end
      if (tx_step) begin
        tx_pend_q      <= 1'b1;
        tx_pend_byte_q <= mem_rdata;
      end else if (pend_send) begin
        tx_pend_q <= 1'b0;
      end
    end
  end

  assign reg_rdata  = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign tx_valid   = txv_q;
  assign tx_byte    = txb_q;
  assign mem_req    = req_q;
  assign mem_we     = we_q;
  assign mem_addr   = maddr_q;
  assign mem_wdata  = mwdata_q;
  assign irq        = irq_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_tx_launch: assert property (wr_byte |=> txv_q && txb_q == $past(reg_wdata[7:0]))
    else $error("byte port write not sent next cycle");
  chk_empty_read: assert property (rd_byte && rxf.empty |=> rvalid_q && rdata_q == `DSP_EMPTY_READ)
    else $error("empty byte port read not all ones");
  chk_fill_read: assert property (reg_rd && reg_addr == `DSP_OFF_FILL |=> rdata_q == 32'($past(rxf.count)))
    else $error("fill level read wrong");
  chk_irq_gate: assert property (mask_q[`DSP_IRQ_RXNE] && !rxf.empty ##1 mask_q[`DSP_IRQ_RXNE] |-> irq_q)
    else $error("enabled not-empty source missing from interrupt");
  chk_irq_masked: assert property (mask_q == 3'h0 |=> !irq_q)
    else $error("interrupt raised with every source masked");
  chk_zero_start: assert property (wr_tx_rem && reg_wdata == `DSP_ZERO_WORD && mem_state_q != DSP_MEM_TX
                                   |=> tx_rem_q == `DSP_ZERO_WORD ##1 (!req_q || we_q))
    else $error("zero count write started a transmit");
  chk_count_step: assert property (rx_ack && rx_rem_q != `DSP_ZERO_WORD && !wr_rx_rem && !wr_rx_ptr
                                   |=> rx_rem_q == $past(rx_rem_q) - `DSP_ONE_WORD && rx_ptr_q == $past(rx_ptr_q) + `DSP_ONE_WORD)
    else $error("receive step did not move address and count");
  chk_idle_stop: assert property (mem_idle && src_txz && src_rxz |=> !req_q)
    else $error("memory access started with both counts zero");
  chk_depth_read: assert property (reg_rd && reg_addr == `DSP_OFF_DEPTH |=> rdata_q == 32'(FIFO_DEPTH))
    else $error("depth register wrong");
  chk_rx_order: assert property (rx_go |=> we_q && mwdata_q == $past(rxf.head))
    else $error("receive channel did not take the oldest byte");
endmodule // dsp_serial_top

//--- dsp_cfg.svh
`ifndef DSP_CFG_SVH
`define DSP_CFG_SVH

// Register offsets within the 4-Kbyte region
`define DSP_OFF_IDENT      12'h000
`define DSP_OFF_BYTE_PORT  12'h004
`define DSP_OFF_FILL       12'h008
`define DSP_OFF_MASK       12'h00c
`define DSP_OFF_TX_PTR     12'h010
`define DSP_OFF_TX_REM     12'h014
`define DSP_OFF_RX_PTR     12'h018
`define DSP_OFF_RX_REM     12'h01c
`define DSP_OFF_DEPTH      12'h020

// Identity value is arbitrary
`define DSP_IDENT_VALUE    32'h5a5a_0001
// Byte port read when the receive queue is empty
`define DSP_EMPTY_READ     32'hffff_ffff
`define DSP_ZERO_WORD      32'h0000_0000
`define DSP_ONE_WORD       32'h0000_0001
`define DSP_FIFO_DEPTH_DEF 16

// Interrupt mask field
`define DSP_MASK_W         3
`define DSP_IRQ_RXNE       0
`define DSP_IRQ_TXZ        1
`define DSP_IRQ_RXZ        2
`define DSP_MASK_RESET     3'h0

`endif

//--- dsp_pkg.sv
package dsp_pkg;

  // Owner of the single memory master port
  typedef enum logic [1:0] {
    DSP_MEM_IDLE = 2'b00,
    DSP_MEM_TX   = 2'b01,
    DSP_MEM_RX   = 2'b10
  } dsp_mem_e;

  typedef logic [7:0] dsp_byte_t;

endpackage

//--- dsp_fifo_if.sv
`timescale 1ns/1ps
interface dsp_fifo_if #(
  parameter int DEPTH = 16,
  parameter int CW    = $clog2(DEPTH + 1)
);
  logic          push;
  logic [7:0]    push_data;
  logic          pop;
  logic [7:0]    head;
  logic [CW-1:0] count;
  logic          empty;
  logic          full;

  modport fifo (input push, input push_data, input pop, output head, output count, output empty, output full);
  modport user (output push, output push_data, output pop, input head, input count, input empty, input full);
endinterface

//--- dsp_rx_fifo.sv
`timescale 1ns/1ps
module dsp_rx_fifo
  import dsp_pkg::*;
#(
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst_b,
  dsp_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("dsp_rx_fifo: DEPTH must be a power of two, at least 2");
    end
  endgenerate

  dsp_byte_t        mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [CW-1:0]    count_q;
  logic             push_ok;
  logic             pop_ok;

  // A full queue drops the new byte; a pop in the same cycle makes room
  assign f.empty   = (count_q == '0);
  assign f.full    = (count_q == CW'(DEPTH));
  assign push_ok   = f.push && (!f.full || f.pop);
  assign pop_ok    = f.pop && !f.empty;
  assign f.head    = mem_q[rd_ptr_q];
  assign f.count   = count_q;

  // Storage is not reset; only pointers and count carry state
  always_ff @(posedge clock) begin
    if (push_ok) begin
      mem_q[wr_ptr_q] <= f.push_data;
    end
  end

  // Pointers and fill count
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push_ok) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      if (pop_ok) begin
        rd_ptr_q <= rd_ptr_q + AW'(1);
      end
      case ({push_ok, pop_ok})
        2'b10:   count_q <= count_q + CW'(1);
        2'b01:   count_q <= count_q - CW'(1);
        default: count_q <= count_q;
      endcase
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  chk_full_drop: assert property (f.full && f.push && !f.pop |=> count_q == CW'(DEPTH))
    else $error("full queue changed level on a dropped push");
  chk_fifo_fill: assert property (!f.full && f.push && !f.pop |=> count_q == $past(count_q) + CW'(1))
    else $error("queue did not take a byte while not full");
endmodule // dsp_rx_fifo

//--- dsp_mem_model.sv
`timescale 1ns/1ps
// System memory behind the master port: acks after 0..3 idle cycles
module dsp_mem_model (
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             mem_ack
);
  logic [7:0]  wq[$];
  logic [31:0] aq[$];
  int          wait_n;

  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 8'h00;
    wait_n    = 0;
  end

  // Answer on falling edges; read data is junk outside the ack cycle
  always @(negedge clock) begin
    if (mem_ack) begin
      mem_ack   <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end else if (rst_b && mem_req) begin
      if (wait_n == 0) begin
        mem_ack   <= 1'b1;
        mem_rdata <= mem_addr[7:0] ^ 8'h5a;
        if (mem_we) begin
          wq.push_back(mem_wdata);
          aq.push_back(mem_addr);
        end
        wait_n <= $urandom_range(0, 3);
      end else begin
        wait_n <= wait_n - 1;
      end
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // dsp_mem_model

//--- dma_serial_port_bench.sv
`timescale 1ns/1ps
`include "dsp_cfg.svh"
module dma_serial_port_bench
  import dsp_pkg::*;
();
  localparam int DEPTH = 4;
  logic        clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, rx_valid = 0;
  logic [11:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, mem_addr, v, a, b;
  logic [7:0]  rx_byte = 0, tx_byte, mem_wdata, mem_rdata, x;
  logic        reg_rvalid, tx_valid, mem_req, mem_we, mem_ack, irq;
  logic [7:0]  txq[$], expq[$];
  int          errors = 0, compares = 0, n;

  // A four-entry queue keeps a full queue cheap to reach
  dsp_serial_top #(.FIFO_DEPTH(DEPTH)) dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .tx_valid(tx_valid), .tx_byte(tx_byte), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .irq(irq));
  dsp_mem_model mem (.clock(clock), .rst_b(rst_b), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  always #2.5 clock = ~clock;

  // Serial output capture, away from the launching edge
  always @(negedge clock) begin
    if (tx_valid === 1'b1) txq.push_back(tx_byte);
  end

  function automatic logic [7:0] exp_mem(input logic [31:0] ad);
    return ad[7:0] ^ 8'h5a;
  endfunction

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    @(negedge clock);
    reg_wr = 1; reg_addr = ad; reg_wdata = d;
    @(negedge clock);
    reg_wr = 0;
  endtask

  task automatic rd_chk(input logic [11:0] ad, input logic [31:0] exp, input string msg);
    @(negedge clock);
    reg_rd = 1; reg_addr = ad;
    @(negedge clock);
    reg_rd = 0;
    check_word({31'h0, reg_rvalid}, 32'h1, "rvalid");
    check_word(reg_rdata, exp, msg);
  endtask

  task automatic rx_send(input logic [7:0] d);
    @(negedge clock);
    rx_valid = 1; rx_byte = d;
    @(negedge clock);
    rx_valid = 0;
  endtask

  // Poll a count register; bounded so a stuck channel fails
  task automatic wait_zero(input logic [11:0] ad);
    int k;
    k = 0;
    do begin
      @(negedge clock); reg_rd = 1; reg_addr = ad;
      @(negedge clock); reg_rd = 0; k++;
    end while (reg_rdata !== 32'h0 && k < 100);
    check_word(reg_rdata, 32'h0, "count reaches zero");
  endtask

  task automatic give_verdict();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #100000;
    errors++;
    $display("watchdog expired");
    give_verdict();
  end

  initial begin
    logic [11:0] offs[10] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h01c, 12'h020, 12'h024};
    logic [31:0] rv[10] = '{`DSP_IDENT_VALUE, `DSP_EMPTY_READ, 0, 0, 0, 0, 0, 0, DEPTH, 0};
    void'($urandom(32'h5607));
    repeat (8) @(negedge clock);
    rst_b = 1;
    for (int i = 0; i < 10; i++) rd_chk(offs[i], rv[i], "reset value");
    check_word({31'h0, irq}, 32'h0, "irq masked");
    $display("test reset done");
    for (int i = 0; i < 3; i++) begin
      x = $urandom;
      wr(`DSP_OFF_BYTE_PORT, {24'h0, x});
      repeat (2) @(negedge clock);
      check_word({31'h0, txq.size() == 1}, 32'h1, "one byte out");
      check_word(txq.pop_front(), x, "tx byte");
    end
    $display("test byte_tx done");
    for (int i = 0; i < DEPTH + 2; i++) begin
      x = $urandom;
      if (i < DEPTH) expq.push_back(x);
      rx_send(x);
    end
    rd_chk(`DSP_OFF_FILL, DEPTH, "fill full");
    wr(`DSP_OFF_MASK, 32'hff);
    rd_chk(`DSP_OFF_MASK, 32'h7, "mask width");
    wr(`DSP_OFF_MASK, 32'h1);
    repeat (2) @(negedge clock);
    check_word({31'h0, irq}, 32'h1, "not empty irq");
    while (expq.size() > 0) rd_chk(`DSP_OFF_BYTE_PORT, {24'h0, expq.pop_front()}, "pop order");
    rd_chk(`DSP_OFF_BYTE_PORT, `DSP_EMPTY_READ, "empty pop");
    check_word({31'h0, irq}, 32'h0, "empty no irq");
    for (int i = 1; i < 3; i++) begin
      wr(`DSP_OFF_MASK, 32'h1 << i);
      repeat (2) @(negedge clock);
      check_word({31'h0, irq}, 32'h1, "count zero irq");
    end
    $display("test rx_queue done");
    a = $urandom; n = $urandom_range(2, 6); txq.delete();
    wr(`DSP_OFF_TX_PTR, a);
    wr(`DSP_OFF_TX_REM, n);
    wait_zero(`DSP_OFF_TX_REM);
    repeat (4) @(negedge clock);
    check_word(txq.size(), n, "tx dma count");
    for (int i = 0; i < n; i++) check_word(txq[i], exp_mem(a + i), "tx dma byte");
    rd_chk(`DSP_OFF_TX_PTR, a + n, "tx ptr end");
    wr(`DSP_OFF_TX_REM, 0);
    repeat (10) @(negedge clock);
    check_word({31'h0, mem_req}, 32'h0, "zero write idle");
    $display("test tx_dma done");
    b = $urandom; mem.wq.delete(); mem.aq.delete();
    for (int i = 0; i < 3; i++) begin x = $urandom; expq.push_back(x); rx_send(x); end
    wr(`DSP_OFF_RX_PTR, b);
    wr(`DSP_OFF_RX_REM, 5);
    for (int i = 0; i < 2; i++) begin x = $urandom; expq.push_back(x); rx_send(x); end
    wait_zero(`DSP_OFF_RX_REM);
    repeat (4) @(negedge clock);
    check_word(mem.wq.size(), 5, "rx dma count");
    for (int i = 0; i < 5 && i < mem.wq.size(); i++) begin
      check_word(mem.wq[i], expq[i], "rx dma byte");
      check_word(mem.aq[i], b + i, "rx dma addr");
    end
    rd_chk(`DSP_OFF_TX_PTR, a + n, "tx ptr untouched");
    $display("test rx_dma done");
    wr(`DSP_OFF_MASK, 32'h4);
    wr(`DSP_OFF_RX_PTR, b);
    wr(`DSP_OFF_RX_REM, 4);
    rd_chk(`DSP_OFF_RX_REM, 4, "live count");
    check_word({31'h0, irq}, 32'h0, "count nonzero");
    rx_send($urandom);
    repeat (12) @(negedge clock);
    rd_chk(`DSP_OFF_RX_REM, 3, "live count step");
    wr(`DSP_OFF_RX_REM, 0);
    rd_chk(`DSP_OFF_RX_PTR, b + 1, "abort progress");
    rx_send($urandom);
    repeat (12) @(negedge clock);
    rd_chk(`DSP_OFF_FILL, 1, "stopped channel");
    check_word({31'h0, irq}, 32'h1, "count zero again");
    $display("test abort done");
    give_verdict();
  end
endmodule // dma_serial_port_bench
